// [hdl/flash_self_program_control.sv]
// Run-time self-programming controller with holding buffer and unlock key.
// Assumes a single Avalon-MM master and a flash array with one-cycle reads.
// Function
// - Target address is page byte plus offset.
// - Low table access covers bits 15 to 0.
// - High table access covers bits 23 to 16.
// - Rows hold 64 instructions, 192 bytes.
// - Erase eight-row page; program row or word.
// - Pages and rows aligned from memory start.
// - 64-word buffer loaded by software per row.
// - Table write fills buffer only, two cycles.
// - Each row needs its own programming cycle.
// - Key 55h then AAh gates the start.
// - Key reads zero, upper byte unimplemented.
// - Operation lasts 4 ms, processor stalled.
// - Start bit set by software, cleared by hardware.
// - Permit bit enables program and erase.
// - Fault flag marks improper sequence attempts.
// - Erase select picks erase or program.
// - Erase decode of operation select code.
// - Program decode of operation select code.
// - Other codes are treated as unimplemented.
// - Control bits cleared only by power-on reset.
// - Unimplemented control bits read zero.
`timescale 1ns/1ps
module flash_self_program_control
#(
	parameter int OP_CYCLES = flash_self_program_pkg::OP_CYCLES
)
(
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	input wire logic POWER_ON_RESET_I,
	input wire logic [4:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	output logic [23:0] FLASH_RD_ADDR_O,
	input wire logic [23:0] FLASH_RD_DATA_I,
	output flash_self_program_pkg::flash_cmd_type FLASH_CMD_O,
	output logic CPU_STALL_O
);
	// Width of the operation timer.
	localparam int TW = $clog2(OP_CYCLES + 1);
	// Last value of the operation timer.
	localparam logic [TW-1:0] TIMER_LAST = TW'(OP_CYCLES - 1);
	// Number of buffer entries.
	localparam int BW = flash_self_program_pkg::ROW_WORDS;
	// Alignment widths used by the command address.
	localparam int ROW_ALIGN = flash_self_program_pkg::ROW_ALIGN_BITS;
	localparam int PAGE_ALIGN = flash_self_program_pkg::PAGE_ALIGN_BITS;

	// Operation sequencer states.
	typedef enum logic [2:0]
	{
		SEQ_IDLE = 3'b001,
		SEQ_TIMING = 3'b010,
		SEQ_COMMIT = 3'b100
	} seq_type;

	// Unlock progress states.
	typedef enum logic [2:0]
	{
		KEY_LOCKED = 3'b001,
		KEY_HALF = 3'b010,
		KEY_ARMED = 3'b100
	} key_type;

	// Either reset clears the ordinary state.
	logic any_reset;
	// Operation control register.
	flash_self_program_pkg::control_type control;
	// Control value merged from the bus write and the stored value.
	flash_self_program_pkg::control_type next_control;
	// Unlock progress.
	key_type key_state;
	// Sequencer state.
	seq_type seq;
	// Table page register and effective offset register.
	logic [7:0] table_page_register;
	logic [15:0] effective_offset;
	// Target address of the last table write.
	logic [23:0] target;
	// Holding buffer for one row of instructions.
	logic [23:0] holding [BW];
	// Bus answer flag and table read wait flag.
	logic ack;
	logic pend;
	// Operation timer and commit index.
	logic [TW-1:0] timer;
	logic [5:0] commit_idx;
	// Decoded request signals.
	logic req;
	logic is_table_read;
	logic done_xfer;
	logic wr_take;
	logic [2:0] reg_sel;
	logic start_try;
	logic start_ok;
	logic op_finish;
	flash_self_program_pkg::op_kind_type next_kind;
	flash_self_program_pkg::op_kind_type run_kind;
	logic row_run;
	logic [5:0] tgt_idx;

	// Classifies an erase select and operation code pair.
	function automatic flash_self_program_pkg::op_kind_type kind_of(input logic erase,
		input logic [3:0] op);
		flash_self_program_pkg::op_kind_type k;
		k = flash_self_program_pkg::KIND_UNIMPL;
		if (erase)
		begin
			// Erase variants, two codes do nothing.
			unique case (op)
				flash_self_program_pkg::OP_BULK,
				flash_self_program_pkg::OP_GENERAL_SEG,
				flash_self_program_pkg::OP_SECURE_SEG,
				flash_self_program_pkg::OP_PAGE_OR_NOP,
				flash_self_program_pkg::OP_CONFIG_BYTE: k = flash_self_program_pkg::KIND_RUN;
				flash_self_program_pkg::OP_WORD_OR_NOP,
				flash_self_program_pkg::OP_ROW_OR_NOP: k = flash_self_program_pkg::KIND_NOP;
				default: k = flash_self_program_pkg::KIND_UNIMPL;
			endcase
		end
		else
		begin
			// Program variants, four codes do nothing.
			unique case (op)
				flash_self_program_pkg::OP_WORD_OR_NOP,
				flash_self_program_pkg::OP_ROW_OR_NOP,
				flash_self_program_pkg::OP_CONFIG_BYTE: k = flash_self_program_pkg::KIND_RUN;
				flash_self_program_pkg::OP_BULK,
				flash_self_program_pkg::OP_GENERAL_SEG,
				flash_self_program_pkg::OP_SECURE_SEG,
				flash_self_program_pkg::OP_PAGE_OR_NOP: k = flash_self_program_pkg::KIND_NOP;
				default: k = flash_self_program_pkg::KIND_UNIMPL;
			endcase
		end
		return k;
	endfunction

	// Request decode and handshake terms.
	assign any_reset = RESET_I | POWER_ON_RESET_I;
	assign req = AVS_READ_I | AVS_WRITE_I;
	assign reg_sel = AVS_ADDRESS_I[4:2];
	assign is_table_read = AVS_READ_I &
		((AVS_ADDRESS_I == flash_self_program_pkg::OFS_DATA_LOW) |
		(AVS_ADDRESS_I == flash_self_program_pkg::OFS_DATA_HIGH));
	assign done_xfer = req & ack;
	assign wr_take = done_xfer & AVS_WRITE_I;
	// The processor is held off for the whole operation.
	assign AVS_WAITREQUEST_O = ~ack;
	assign CPU_STALL_O = control.start;
	// Table reads look at the current table pointer.
	assign FLASH_RD_ADDR_O = {table_page_register, effective_offset};
	assign tgt_idx = target[6:1];

	// Merges byte-enabled write data with the stored control bits.
	always_comb
	begin
		next_control = control;
		if (AVS_BYTEENABLE_I[0])
		begin
			next_control.erase = AVS_WRITEDATA_I[flash_self_program_pkg::BIT_ERASE];
			next_control.op = AVS_WRITEDATA_I[3:0];
		end
		if (AVS_BYTEENABLE_I[1])
		begin
			next_control.permit = AVS_WRITEDATA_I[flash_self_program_pkg::BIT_PERMIT];
			next_control.fault = AVS_WRITEDATA_I[flash_self_program_pkg::BIT_FAULT];
		end
	end

	// Start attempt and its admission check.
	assign next_kind = kind_of(next_control.erase, next_control.op);
	assign start_try = wr_take & (AVS_ADDRESS_I == flash_self_program_pkg::OFS_CONTROL) &
		AVS_BYTEENABLE_I[1] & AVS_WRITEDATA_I[flash_self_program_pkg::BIT_START];
	assign start_ok = (key_state == KEY_ARMED) & next_control.permit &
		(next_kind != flash_self_program_pkg::KIND_UNIMPL);
	// Decode of the running operation.
	assign run_kind = kind_of(control.erase, control.op);
	assign row_run = ~control.erase & (control.op == flash_self_program_pkg::OP_ROW_OR_NOP);
	// The commit stage ends after one cycle, or after a whole row.
	assign op_finish = (seq == SEQ_COMMIT) & (~row_run | (commit_idx == 6'(BW - 1)));

	// Bus handshake: writes answer after one wait cycle, table reads after two.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (any_reset)
		begin
			ack <= 1'b0;
			pend <= 1'b0;
		end
		else if (ack)
		begin
			// The answer stands for one cycle only.
			ack <= 1'b0;
		end
		else if (req & ~control.start)
		begin
			// Nothing is answered while an operation runs.
			if (is_table_read & ~pend)
			begin
				pend <= 1'b1;
			end
			else
			begin
				pend <= 1'b0;
				ack <= 1'b1;
			end
		end
	end

	// Read data is captured as the answer is raised.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (any_reset)
		begin
			AVS_READDATA_O <= 32'h0000_0000;
		end
		else if (req & ~ack & ~control.start & (~is_table_read | pend))
		begin
			unique case (AVS_ADDRESS_I)
				flash_self_program_pkg::OFS_CONTROL:
				begin
					// Unimplemented control bits read as zero.
					AVS_READDATA_O <= {16'h0000, control.start, control.permit,
						control.fault, 6'b00_0000, control.erase, 2'b00, control.op};
				end
				flash_self_program_pkg::OFS_PAGE:
				begin
					AVS_READDATA_O <= {24'h00_0000, table_page_register};
				end
				flash_self_program_pkg::OFS_OFFSET:
				begin
					AVS_READDATA_O <= {16'h0000, effective_offset};
				end
				flash_self_program_pkg::OFS_DATA_LOW:
				begin
					AVS_READDATA_O <= {16'h0000, FLASH_RD_DATA_I[15:0]};
				end
				flash_self_program_pkg::OFS_DATA_HIGH:
				begin
					// The upper byte of the high word is a phantom zero.
					AVS_READDATA_O <= {24'h00_0000, FLASH_RD_DATA_I[23:16]};
				end
				default:
				begin
					// The key reads zero, as do unmapped offsets.
					AVS_READDATA_O <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Table pointer registers, written a byte lane at a time.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (any_reset)
		begin
			table_page_register <= flash_self_program_pkg::PAGE_RESET;
			effective_offset <= flash_self_program_pkg::OFFSET_RESET;
		end
		else if (wr_take)
		begin
			if ((AVS_ADDRESS_I == flash_self_program_pkg::OFS_PAGE) & AVS_BYTEENABLE_I[0])
			begin
				table_page_register <= AVS_WRITEDATA_I[7:0];
			end
			if (AVS_ADDRESS_I == flash_self_program_pkg::OFS_OFFSET)
			begin
				if (AVS_BYTEENABLE_I[0])
				begin
					effective_offset[7:0] <= AVS_WRITEDATA_I[7:0];
				end
				if (AVS_BYTEENABLE_I[1])
				begin
					effective_offset[15:8] <= AVS_WRITEDATA_I[15:8];
				end
			end
		end
	end

	// Table writes land in the holding buffer, never in the array.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (wr_take & (AVS_ADDRESS_I == flash_self_program_pkg::OFS_DATA_LOW))
		begin
			// Word position in the row comes from the offset, two units apart.
			if (AVS_BYTEENABLE_I[0])
			begin
				holding[effective_offset[6:1]][7:0] <= AVS_WRITEDATA_I[7:0];
			end
			if (AVS_BYTEENABLE_I[1])
			begin
				holding[effective_offset[6:1]][15:8] <= AVS_WRITEDATA_I[15:8];
			end
		end
		if (wr_take & (AVS_ADDRESS_I == flash_self_program_pkg::OFS_DATA_HIGH) &
			AVS_BYTEENABLE_I[0])
		begin
			holding[effective_offset[6:1]][23:16] <= AVS_WRITEDATA_I[7:0];
		end
	end

	// The last table write also names the target of the next operation.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (any_reset)
		begin
			target <= 24'h00_0000;
		end
		else if (wr_take & ((AVS_ADDRESS_I == flash_self_program_pkg::OFS_DATA_LOW) |
			(AVS_ADDRESS_I == flash_self_program_pkg::OFS_DATA_HIGH)))
		begin
			target <= {table_page_register, effective_offset};
		end
	end

	// Unlock tracking: only 55h then AAh, with no other write between, arms.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (any_reset)
		begin
			key_state <= KEY_LOCKED;
		end
		else if (wr_take)
		begin
			if ((AVS_ADDRESS_I == flash_self_program_pkg::OFS_KEY) & AVS_BYTEENABLE_I[0] &
				(AVS_WRITEDATA_I[7:0] == flash_self_program_pkg::KEY_FIRST))
			begin
				key_state <= KEY_HALF;
			end
			else if ((AVS_ADDRESS_I == flash_self_program_pkg::OFS_KEY) &
				AVS_BYTEENABLE_I[0] & (key_state == KEY_HALF) &
				(AVS_WRITEDATA_I[7:0] == flash_self_program_pkg::KEY_SECOND))
			begin
				key_state <= KEY_ARMED;
			end
			else
			begin
				// Any other write, a control write included, drops the unlock.
				key_state <= KEY_LOCKED;
			end
		end
	end

	// Control register, cleared by power-on reset alone.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (POWER_ON_RESET_I)
		begin
			control <= flash_self_program_pkg::CONTROL_RESET;
		end
		else if (op_finish)
		begin
			// Completion clears the start bit; the fault flag stays clear.
			control.start <= 1'b0;
		end
		else if (wr_take & (AVS_ADDRESS_I == flash_self_program_pkg::OFS_CONTROL))
		begin
			control.permit <= next_control.permit;
			control.erase <= next_control.erase;
			control.op <= next_control.op;
			if (start_try & start_ok)
			begin
				// A proper launch starts with a clear fault flag.
				control.start <= 1'b1;
				control.fault <= 1'b0;
			end
			else if (start_try)
			begin
				// A refused start sets the flag, winning over the written value.
				control.fault <= 1'b1;
			end
			else
			begin
				control.fault <= next_control.fault;
			end
		end
	end

	// Self-timed sequencer: timing phase, then the array commands.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (POWER_ON_RESET_I)
		begin
			seq <= SEQ_IDLE;
			timer <= '0;
			commit_idx <= 6'h00;
		end
		else
		begin
			unique case (seq)
				SEQ_IDLE:
				begin
					timer <= '0;
					commit_idx <= 6'h00;
					if (start_try & start_ok)
					begin
						seq <= SEQ_TIMING;
					end
				end
				SEQ_TIMING:
				begin
					// The operation holds for its nominal time.
					if (timer == TIMER_LAST)
					begin
						seq <= SEQ_COMMIT;
					end
					else
					begin
						timer <= timer + TW'(1);
					end
				end
				SEQ_COMMIT:
				begin
					commit_idx <= commit_idx + 6'h01;
					if (op_finish)
					begin
						seq <= SEQ_IDLE;
					end
				end
			endcase
		end
	end

	// Array commands issued during the commit phase.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (POWER_ON_RESET_I)
		begin
			FLASH_CMD_O <= flash_self_program_pkg::CMD_IDLE;
		end
		else if ((seq == SEQ_COMMIT) & (run_kind == flash_self_program_pkg::KIND_RUN))
		begin
			FLASH_CMD_O.valid <= 1'b1;
			FLASH_CMD_O.erase <= control.erase;
			FLASH_CMD_O.op <= control.op;
			if (row_run)
			begin
				// A row streams all 64 buffer words from its aligned base.
				FLASH_CMD_O.addr <= {target[23:ROW_ALIGN], commit_idx, 1'b0};
				FLASH_CMD_O.data <= holding[commit_idx];
			end
			else if (control.erase & (control.op == flash_self_program_pkg::OP_PAGE_OR_NOP))
			begin
				// A page is eight rows, aligned to its own size.
				FLASH_CMD_O.addr <= {target[23:PAGE_ALIGN], PAGE_ALIGN'(0)};
				FLASH_CMD_O.data <= 24'h00_0000;
			end
			else
			begin
				// Word, byte and segment operations use the target as given.
				FLASH_CMD_O.addr <= target;
				FLASH_CMD_O.data <= holding[tgt_idx];
			end
		end
		else
		begin
			// Codes that do nothing still run the timed cycle quietly.
			FLASH_CMD_O <= flash_self_program_pkg::CMD_IDLE;
		end
	end
endmodule

// [pkg/flash_self_program_pkg.sv]
// Package for the flash self-programming controller.
// Assumes one 250 MHz clock and a 32-bit Avalon-MM register bus.
package flash_self_program_pkg;
	// Clock rate in MHz and the nominal operation time in microseconds.
	localparam int CLK_MHZ = 250;
	localparam int OP_TIME_US = 4000;
	// Cycles of one self-timed operation, derived from time and rate.
	localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
	// Byte offsets of the registers on the bus.
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_KEY = 5'h04;
	localparam logic [4:0] OFS_PAGE = 5'h08;
	localparam logic [4:0] OFS_OFFSET = 5'h0C;
	localparam logic [4:0] OFS_DATA_LOW = 5'h10;
	localparam logic [4:0] OFS_DATA_HIGH = 5'h14;
	// Field positions in the operation control register.
	localparam int BIT_START = 15;
	localparam int BIT_PERMIT = 14;
	localparam int BIT_FAULT = 13;
	localparam int BIT_ERASE = 6;
	// Unlock key values, in the order they must arrive.
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	// Operation select codes.
	localparam logic [3:0] OP_BULK = 4'hF;
	localparam logic [3:0] OP_GENERAL_SEG = 4'hD;
	localparam logic [3:0] OP_SECURE_SEG = 4'hC;
	localparam logic [3:0] OP_WORD_OR_NOP = 4'h3;
	localparam logic [3:0] OP_PAGE_OR_NOP = 4'h2;
	localparam logic [3:0] OP_ROW_OR_NOP = 4'h1;
	localparam logic [3:0] OP_CONFIG_BYTE = 4'h0;
	// Row and page geometry, in instructions and address bits.
	localparam int ROW_WORDS = 64;
	localparam int ROW_ALIGN_BITS = 7;
	localparam int PAGE_ALIGN_BITS = 10;
	// Reset values.
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	// Kinds of decoded operation.
	typedef enum logic [1:0]
	{
		KIND_UNIMPL = 2'b00,
		KIND_NOP = 2'b01,
		KIND_RUN = 2'b10
	} op_kind_type;
	// Operation control register contents.
	typedef struct packed
	{
		logic start;
		logic permit;
		logic fault;
		logic erase;
		logic [3:0] op;
	} control_type;
	localparam control_type CONTROL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 4'h0};
	// One command to the flash array.
	typedef struct packed
	{
		logic valid;
		logic erase;
		logic [3:0] op;
		logic [23:0] addr;
		logic [23:0] data;
	} flash_cmd_type;
	localparam flash_cmd_type CMD_IDLE = '{1'b0, 1'b0, 4'h0, 24'h00_0000, 24'h00_0000};
endpackage

// [tb/cpu_bus_model.sv]
// Processor-side model issuing register and table accesses.
// Assumes an Avalon-MM slave that answers by dropping waitrequest.
`timescale 1ns/1ps
module cpu_bus_model
(
	input wire logic clk_i,
	input wire logic [31:0] readdata_i,
	input wire logic waitrequest_i,
	output logic [4:0] address_o = 5'h00,
	output logic read_o = 1'b0,
	output logic write_o = 1'b0,
	output logic [31:0] writedata_o = 32'h0000_0000,
	output logic [3:0] byteenable_o = 4'h0
);
	// One write, held until waitrequest is seen low.
	task automatic bus_write(input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
		@(posedge clk_i);
		address_o <= a;
		writedata_o <= {16'h0000, d};
		byteenable_o <= be;
		write_o <= 1'b1;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		write_o <= 1'b0;
	endtask
	// One read; data is taken at the edge that sees waitrequest low.
	task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_i);
		address_o <= a;
		byteenable_o <= 4'h3;
		read_o <= 1'b1;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		d = readdata_i;
		read_o <= 1'b0;
	endtask
	// Two key writes in a row, in the order given.
	task automatic unlock(input logic [7:0] k1, input logic [7:0] k2);
		bus_write(flash_self_program_pkg::OFS_KEY, {8'h00, k1}, 4'h1);
		bus_write(flash_self_program_pkg::OFS_KEY, {8'h00, k2}, 4'h1);
	endtask
	// Start write followed by two idle cycles.
	task automatic start(input logic [15:0] ctl);
		bus_write(flash_self_program_pkg::OFS_CONTROL, ctl, 4'h3);
		repeat (2) @(posedge clk_i);
	endtask
	// Fills one aligned row with 64 low and 64 high table writes.
	task automatic load_row(input logic [7:0] page, input logic [15:0] base);
		bus_write(flash_self_program_pkg::OFS_PAGE, {8'h00, page}, 4'h1);
		for (int i = 0; i < 64; i++)
		begin
			bus_write(flash_self_program_pkg::OFS_OFFSET, base + 16'(2 * i), 4'h3);
			bus_write(flash_self_program_pkg::OFS_DATA_LOW, 16'hA000 + 16'(i), 4'h3);
			bus_write(flash_self_program_pkg::OFS_DATA_HIGH, {8'h00, 8'h40 + 8'(i)}, 4'h1);
		end
	endtask
endmodule

// [tb/flash_self_program_control_props.sv]
// Port checker for the flash self-programming controller.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module flash_self_program_checker
#(
	parameter int OP_CYCLES = 20
)
(
	input wire logic CORE_CLK_I,
	input wire logic POWER_ON_RESET_I,
	input wire logic [4:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire flash_self_program_pkg::flash_cmd_type FLASH_CMD_O,
	input wire logic CPU_STALL_O
);
	// Cycles the stall has stood in the current operation.
	int stall_cnt;
	// A read answer is being handed back in this cycle.
	logic rd_ans;
	assign rd_ans = AVS_READ_I && !AVS_WAITREQUEST_O;
	default clocking @(posedge CORE_CLK_I);
	endclocking
	default disable iff (POWER_ON_RESET_I);
	// Counts stall cycles so the operation length can be judged at its end.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (POWER_ON_RESET_I || !CPU_STALL_O)
			stall_cnt <= 0;
		else
			stall_cnt <= stall_cnt + 1;
	end
	property p_stall_waits;
		CPU_STALL_O |-> AVS_WAITREQUEST_O;
	endproperty
	a_stall_waits: assert property (p_stall_waits)
		else $error("bus answered during an operation");
	property p_wait_pulse;
		!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse)
		else $error("waitrequest low for more than one cycle");
	property p_cmd_in_op;
		FLASH_CMD_O.valid |-> $past(CPU_STALL_O);
	endproperty
	a_cmd_in_op: assert property (p_cmd_in_op)
		else $error("array command outside an operation");
	property p_op_length;
		$fell(CPU_STALL_O) |-> stall_cnt >= OP_CYCLES;
	endproperty
	a_op_length: assert property (p_op_length)
		else $error("operation ended too early");
	property p_page_align;
		FLASH_CMD_O.valid && FLASH_CMD_O.erase && FLASH_CMD_O.op == 4'h2
			|-> FLASH_CMD_O.addr[9:0] == 10'h000;
	endproperty
	a_page_align: assert property (p_page_align)
		else $error("page erase address not aligned");
	property p_row_step;
		FLASH_CMD_O.valid && !FLASH_CMD_O.erase && FLASH_CMD_O.op == 4'h1
			&& FLASH_CMD_O.addr[6:0] != 7'h7E
			|=> FLASH_CMD_O.valid && FLASH_CMD_O.addr == $past(FLASH_CMD_O.addr) + 24'h00_0002;
	endproperty
	a_row_step: assert property (p_row_step)
		else $error("row burst broken");
	property p_row_start;
		$rose(FLASH_CMD_O.valid) && !FLASH_CMD_O.erase && FLASH_CMD_O.op == 4'h1
			|-> FLASH_CMD_O.addr[6:0] == 7'h00;
	endproperty
	a_row_start: assert property (p_row_start)
		else $error("row burst not aligned");
	property p_word_single;
		FLASH_CMD_O.valid && !FLASH_CMD_O.erase && FLASH_CMD_O.op == 4'h3 |=> !FLASH_CMD_O.valid;
	endproperty
	a_word_single: assert property (p_word_single)
		else $error("word program gave more than one command");
	property p_code_legal;
		FLASH_CMD_O.valid |-> (FLASH_CMD_O.erase ? FLASH_CMD_O.op inside {4'hF, 4'hD, 4'hC, 4'h2, 4'h0}
			: FLASH_CMD_O.op inside {4'h3, 4'h1, 4'h0});
	endproperty
	a_code_legal: assert property (p_code_legal)
		else $error("command for a code without operation");
	property p_key_zero;
		rd_ans && AVS_ADDRESS_I == flash_self_program_pkg::OFS_KEY |-> AVS_READDATA_O == 32'h0000_0000;
	endproperty
	a_key_zero: assert property (p_key_zero)
		else $error("key register read not zero");
	property p_ctl_unused;
		rd_ans && AVS_ADDRESS_I == flash_self_program_pkg::OFS_CONTROL
			|-> AVS_READDATA_O[12:7] == 6'h00 && AVS_READDATA_O[5:4] == 2'h0;
	endproperty
	a_ctl_unused: assert property (p_ctl_unused)
		else $error("unused control bits read nonzero");
	c_row: cover property (FLASH_CMD_O.valid && FLASH_CMD_O.op == 4'h1);
	c_erase: cover property (FLASH_CMD_O.valid && FLASH_CMD_O.erase);
	c_stall: cover property ($fell(CPU_STALL_O));
endmodule
bind flash_self_program_control flash_self_program_checker #(.OP_CYCLES(OP_CYCLES)) u_checker
(
	.CORE_CLK_I(CORE_CLK_I),
	.POWER_ON_RESET_I(POWER_ON_RESET_I),
	.AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I),
	.AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.FLASH_CMD_O(FLASH_CMD_O),
	.CPU_STALL_O(CPU_STALL_O)
);

// [tb/flash_self_program_control_test.sv]
// Self-checking bench for the flash self-programming controller.
// Assumes the processor model and the port checker are compiled alongside.
`timescale 1ns/1ps
module flash_self_program_control_test;
	// Short operation time keeps the run brief.
	localparam int OP_CYCLES = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b1;
	logic [4:0] address;
	logic read;
	logic write;
	logic [31:0] wdata;
	logic [3:0] be;
	logic [31:0] rdata;
	logic waitreq;
	logic [23:0] rd_addr;
	logic [23:0] rd_data = 24'h00_0000;
	logic stall;
	flash_self_program_pkg::flash_cmd_type cmd;
	flash_self_program_pkg::flash_cmd_type cmd_q[$];
	logic [3:0] codes [7] = '{4'hF, 4'hD, 4'hC, 4'h3, 4'h2, 4'h1, 4'h0};
	logic [31:0] d;
	logic [23:0] e;
	int err_total = 0;
	int checks = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	flash_self_program_control #(.OP_CYCLES(OP_CYCLES)) u_flash_self_program_control
	(
		.CORE_CLK_I(clk), .RESET_I(rst), .POWER_ON_RESET_I(por),
		.AVS_ADDRESS_I(address), .AVS_READ_I(read), .AVS_WRITE_I(write),
		.AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(waitreq), .FLASH_RD_ADDR_O(rd_addr), .FLASH_RD_DATA_I(rd_data),
		.FLASH_CMD_O(cmd), .CPU_STALL_O(stall)
	);
	cpu_bus_model u_cpu_bus_model
	(
		.clk_i(clk), .readdata_i(rdata), .waitrequest_i(waitreq), .address_o(address),
		.read_o(read), .write_o(write), .writedata_o(wdata), .byteenable_o(be)
	);
	// Array contents as a fixed pattern of the address.
	function automatic logic [23:0] fdat(input logic [23:0] a);
		return {a[7:0] ^ 8'hC3, a[15:0] ^ 16'h5A5A};
	endfunction
	// Commands expected for a code under each erase setting.
	function automatic int exp_count(input logic er, input logic [3:0] op);
		if (er)
			return (op == 4'h3 || op == 4'h1) ? 0 : 1;
		return (op == 4'h1) ? 64 : ((op == 4'h3 || op == 4'h0) ? 1 : 0);
	endfunction
	// Array stand-in answers one cycle after the address; commands are logged.
	always @(posedge clk)
	begin
		rd_data <= fdat(rd_addr);
		if (cmd.valid === 1'b1)
			cmd_q.push_back(cmd);
		cycles <= cycles + 1;
		if (cycles == 10000)
		begin
			err_total++;
			stop_test();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Unlocks, starts one operation and checks its outcome.
	task automatic run_op(input logic er, input logic [3:0] op, input logic flt);
		int n;
		n = flt ? 0 : exp_count(er, op);
		cmd_q.delete();
		u_cpu_bus_model.bus_write(flash_self_program_pkg::OFS_CONTROL, {8'h40, 1'b0, er, 2'b00, op}, 4'h3);
		u_cpu_bus_model.unlock(8'h55, 8'hAA);
		u_cpu_bus_model.start({8'hC0, 1'b0, er, 2'b00, op});
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_CONTROL, d);
		cmp(d, {16'h0000, 2'b01, flt, 6'h00, er, 2'b00, op}, "control");
		cmp(32'(cmd_q.size()), 32'(n), "count");
		if (n > 0)
			cmp(32'({cmd_q[0].erase, cmd_q[0].op}), 32'({er, op}), "kind");
		if (n == 1 && er && op == 4'h2)
			cmp(32'(cmd_q[0].addr), 32'h0001_0000, "page");
		if (n == 1 && !er && op == 4'h3)
			cmp(32'(cmd_q[0].addr), 32'h0001_00FE, "word");
		for (int i = 0; i < n && n == 64; i++)
		begin
			cmp(32'(cmd_q[i].addr), 32'(24'h01_0080 + 24'(2 * i)), "row addr");
			cmp(32'(cmd_q[i].data), 32'({8'h40 + 8'(i), 16'hA000 + 16'(i)}), "row data");
		end
	endtask
	// Key order broken, or key followed by another write, then a start.
	task automatic bad_key(input logic [7:0] k1, input logic [7:0] k2, input logic extra);
		u_cpu_bus_model.bus_write(flash_self_program_pkg::OFS_CONTROL, 16'h4001, 4'h3);
		u_cpu_bus_model.unlock(k1, k2);
		if (extra)
			u_cpu_bus_model.bus_write(flash_self_program_pkg::OFS_PAGE, 16'h0001, 4'h1);
		u_cpu_bus_model.start(16'hC001);
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_CONTROL, d);
		cmp(d, 32'h0000_6001, "refused");
		cmp(32'(stall), 32'h0000_0000, "stall");
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_CONTROL, d);
		cmp(d, 32'h0000_0000, "control reset");
		u_cpu_bus_model.bus_read(5'h18, d);
		cmp(d, 32'h0000_0000, "unmapped");
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_KEY, d);
		cmp(d, 32'h0000_0000, "key read");
		u_cpu_bus_model.bus_write(flash_self_program_pkg::OFS_CONTROL, 16'hDFFF, 4'h3);
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_CONTROL, d);
		cmp(d, 32'h0000_604F, "locked start");
		$display("register test done");
		u_cpu_bus_model.bus_write(flash_self_program_pkg::OFS_PAGE, 16'h0012, 4'h1);
		u_cpu_bus_model.bus_write(flash_self_program_pkg::OFS_OFFSET, 16'h0346, 4'h3);
		e = fdat(24'h12_0346);
		@(posedge clk);
		cmp(32'(rd_addr), 32'h0012_0346, "target");
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_DATA_LOW, d);
		cmp(d, {16'h0000, e[15:0]}, "low read");
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_DATA_HIGH, d);
		cmp(d, {24'h00_0000, e[23:16]}, "high read");
		cmd_q.delete();
		u_cpu_bus_model.load_row(8'h01, 16'h0080);
		cmp(32'(cmd_q.size()), 32'h0000_0000, "no write yet");
		$display("table test done");
		for (int er = 0; er < 2; er++)
			foreach (codes[k])
				run_op(er[0], codes[k], 1'b0);
		run_op(1'b0, 4'h5, 1'b1);
		$display("operation test done");
		bad_key(8'hAA, 8'h55, 1'b0);
		bad_key(8'h55, 8'hAA, 1'b1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_CONTROL, d);
		cmp(d, 32'h0000_6001, "kept by reset");
		@(posedge clk);
		por <= 1'b1;
		repeat (2) @(posedge clk);
		por <= 1'b0;
		u_cpu_bus_model.bus_read(flash_self_program_pkg::OFS_CONTROL, d);
		cmp(d, 32'h0000_0000, "cleared by power-on");
		$display("key and reset test done");
		stop_test();
	end
endmodule
